// File: core/plp_pkg.sv
// Constants shared by both ends of the tuning-synthesizer control link.
// Assumes a single 100 MHz system clock on both ends.
package plp_pkg;
  // System clock
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;

  // Input frame layout, bit 0 shifted in first after the mode bit
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 16;
  localparam int AM_FAST_BIT = 16;
  localparam int FM_SEL_BIT = 17;
  localparam int CNT_EN_BIT = 18;
  localparam int GT_LO_BIT = 19;
  localparam int GT_HI_BIT = 20;
  localparam int IF_SENS_BIT = 21;
  localparam int CFG_W = 22;
  localparam logic [CFG_W-1:0] CFG_RST = 22'h200000;

  // Output frame: port two, port one, unlock flag, count MSB first
  localparam int CNT_W = 20;
  localparam int OUT_W = 23;
  localparam int IN_BITS = 23;
  localparam int RD_BITS = 24;
  localparam logic MODE_WRITE = 1'b1;
  localparam logic MODE_READ = 1'b0;

  // Divisor ranges per mode
  localparam int DIV_MIN_HI = 272;
  localparam int DIV_MAX_HI = 65535;
  localparam int DIV_MIN_LO = 4;
  localparam int DIV_MAX_LO = 4095;

  // IF gate and wait times in ms
  localparam int GATE0_MS = 4;
  localparam int GATE1_MS = 8;
  localparam int GATE2_MS = 32;
  localparam int GATE3_MS = 64;
  localparam int WAIT_SHORT_MS = 3;
  localparam int WAIT_LONG_MS = 7;

  // Link timing: 0.75 us minimum, 1 us used per half clock
  localparam int LINK_MIN_NS = 750;
  localparam int LINK_HALF_NS = 1000;
  localparam int HALF_CYC = LINK_HALF_NS / CLK_NS;

  // Synchroniser lanes on the device end
  localparam int SY_CE = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SIN = 2;
  localparam int SY_FM = 3;
  localparam int SY_AM = 4;
  localparam int SY_IF = 5;
  localparam int SY_IO1 = 6;
  localparam int SY_IO2 = 7;
  localparam int SY_N = 8;
endpackage

// File: core/plp_link_if.sv
// Three-wire control link plus open-drain serial output line.
// The output line is pulled high unless the device drives it low.
`timescale 1ns/1ns
`default_nettype none
interface plp_link_if;
  logic ce;
  logic serial_clock_pin;
  logic serial_in_pin;
  logic do_o;
  logic do_oe;
  logic do_line;

  // Pull-up: released line reads high
  assign do_line = (do_oe && !do_o) ? 1'b0 : 1'b1;

  modport host (output ce, output serial_clock_pin, output serial_in_pin, input do_line);
  modport dev (input ce, input serial_clock_pin, input serial_in_pin, output do_o,
    output do_oe);
endinterface
`default_nettype wire

// File: core/plp_dev.sv
// Device end: serial control receiver, programmable divider, IF counter.
// Assumes all pins are asynchronous to mclk and far slower than it.
//
// Notes on behaviour
// - FM path divides by twice divisor
// - AM fast path divides by divisor
// - Twenty-bit counter counts IF input pulses
// - Count shifted out most significant first
// - Gate select picks 4/8/32/64 ms
// - Host applies IF within wait time; the bench starts IF pulses only after the wait ends
// - Count enable zero clears the counter
// - Count starts on enable rising 0 to 1
// - Configuration latched on strobe falling edge
// - Host reads result before clearing enable
// - Host counts only with station detect
// - Sensitivity bit one normal, zero reduced
// - Unlock flag zero only when unlocked
// - Port levels captured entering output mode
`timescale 1ns/1ns
`default_nettype none
module plp_dev
  import plp_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  plp_link_if.dev link,
  input wire logic fm_rf_input,
  input wire logic am_rf_input,
  input wire logic if_pulse_input,
  input wire logic lock_ok,
  input wire logic io1_level,
  input wire logic io2_level,
  output logic div_pulse,
  output logic fm_path_active,
  output logic if_sensitivity_select,
  output logic count_busy,
  output logic count_done
);
  typedef enum logic [1:0] {
    IF_IDLE = 2'b00,
    IF_WAIT = 2'b01,
    IF_GATE = 2'b10,
    IF_DONE = 2'b11
  } plp_ifst_t;

  function automatic logic [6:0] gate_ms(input logic [1:0] gt);
    unique case (gt)
      2'b00: gate_ms = 7'(GATE0_MS);
      2'b01: gate_ms = 7'(GATE1_MS);
      2'b10: gate_ms = 7'(GATE2_MS);
      2'b11: gate_ms = 7'(GATE3_MS);
    endcase
  endfunction

  logic [SY_N-1:0] raw;
  logic [SY_N-1:0] s1_r, s2_r, s3_r, f_r, fp_r;
  logic [SY_N-1:0] rise, fall;
  logic [CFG_W-1:0] cfg_r, sh_r;
  logic [OUT_W-1:0] out_r;
  logic [4:0] bit_r;
  logic wr_mode_r, out_mode_r;
  logic latch_ev;
  logic [16:0] dcnt_r, dtarget;
  logic dsel_rise;
  plp_ifst_t ifst_r;
  logic [16:0] mscyc_r;
  logic [6:0] ms_r;
  logic ms_tick;
  logic [CNT_W-1:0] cnt_r;
  logic cnt_clr;
  logic do_o_r, do_oe_r, div_pulse_r;

  assign raw = {io2_level, io1_level, if_pulse_input, am_rf_input, fm_rf_input,
                link.serial_in_pin, link.serial_clock_pin, link.ce};

  // A change is accepted only once stages two and three agree
  for (genvar g = 0; g < SY_N; g++) begin : g_sync
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        s3_r[g] <= 1'b0;
        f_r[g] <= 1'b0;
        fp_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          f_r[g] <= s3_r[g];
        end
        fp_r[g] <= f_r[g];
      end
    end
  end
  assign rise = f_r & ~fp_r;
  assign fall = ~f_r & fp_r;

  assign latch_ev = fall[SY_CE] && wr_mode_r && (bit_r == 5'(IN_BITS));

  // only rising clock edges inside the strobe, so idle level is free
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_r <= 5'h00;
      wr_mode_r <= 1'b0;
      out_mode_r <= 1'b0;
      sh_r <= '0;
      out_r <= '0;
    end else if (rise[SY_CE]) begin
      bit_r <= 5'h00;
      wr_mode_r <= 1'b0;
      out_mode_r <= 1'b0;
    end else if (fall[SY_CE]) begin
      wr_mode_r <= 1'b0;
      out_mode_r <= 1'b0;
    end else if (f_r[SY_CE] && rise[SY_SCK]) begin
      if (bit_r != 5'h1F) begin
        bit_r <= bit_r + 5'h01;
      end
      if (bit_r == 5'h00) begin
        wr_mode_r <= (f_r[SY_SIN] == MODE_WRITE);
        out_mode_r <= (f_r[SY_SIN] == MODE_READ);
        out_r <= {f_r[SY_IO2], f_r[SY_IO1], lock_ok, cnt_r};
      end else if (wr_mode_r) begin
        sh_r <= {f_r[SY_SIN], sh_r[CFG_W-1:1]};
      end else if (out_mode_r) begin
        out_r <= {out_r[OUT_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= CFG_RST;
    end else if (latch_ev) begin
      cfg_r <= sh_r;
    end
  end

  // Open drain: drive low only for a zero bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      do_o_r <= 1'b0;
      do_oe_r <= 1'b0;
    end else begin
      do_o_r <= 1'b0;
      do_oe_r <= out_mode_r && f_r[SY_CE] && !out_r[OUT_W-1];
    end
  end

  // AM fast uses it as is
  always_comb begin
    if (cfg_r[FM_SEL_BIT]) begin
      dtarget = {cfg_r[DIV_LSB+DIV_W-1:DIV_LSB], 1'b0};
      dsel_rise = rise[SY_FM];
    end else if (cfg_r[AM_FAST_BIT]) begin
      dtarget = {1'b0, cfg_r[DIV_LSB+DIV_W-1:DIV_LSB]};
      dsel_rise = rise[SY_AM];
    end else begin
      dtarget = {5'h00, cfg_r[DIV_LSB+DIV_W-1:DIV_LSB+4]};
      dsel_rise = rise[SY_AM];
    end
  end

  // Divisors below range still divide; a zero target divides by one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dcnt_r <= 17'h00000;
      div_pulse_r <= 1'b0;
    end else begin
      div_pulse_r <= 1'b0;
      if (latch_ev) begin
        dcnt_r <= 17'h00000;
      end else if (dsel_rise) begin
        if (dcnt_r + 17'h00001 >= dtarget) begin
          dcnt_r <= 17'h00000;
          div_pulse_r <= 1'b1;
        end else begin
          dcnt_r <= dcnt_r + 17'h00001;
        end
      end
    end
  end

  assign ms_tick = (mscyc_r == 17'(MS_CYCLES - 1));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ifst_r <= IF_IDLE;
      mscyc_r <= 17'h00000;
      ms_r <= 7'h00;
    end else if (latch_ev && !sh_r[CNT_EN_BIT]) begin
      ifst_r <= IF_IDLE;
    end else if (latch_ev && !cfg_r[CNT_EN_BIT]) begin
      // start on 0 to 1 only
      ifst_r <= IF_WAIT;
      mscyc_r <= 17'h00000;
      ms_r <= 7'h00;
    end else if (ifst_r == IF_WAIT || ifst_r == IF_GATE) begin
      mscyc_r <= ms_tick ? 17'h00000 : mscyc_r + 17'h00001;
      if (ms_tick) begin
        ms_r <= ms_r + 7'h01;
        if (ifst_r == IF_WAIT) begin
          if (ms_r + 7'h01 == (cfg_r[GT_HI_BIT] ? 7'(WAIT_LONG_MS) : 7'(WAIT_SHORT_MS))) begin
            ifst_r <= IF_GATE;
            ms_r <= 7'h00;
          end
        end else if (ms_r + 7'h01 == gate_ms(cfg_r[GT_HI_BIT:GT_LO_BIT])) begin
          ifst_r <= IF_DONE;
        end
      end
    end
  end

  // zero enable clears, as does a fresh start
  assign cnt_clr = latch_ev && (!sh_r[CNT_EN_BIT] || !cfg_r[CNT_EN_BIT]);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (cnt_clr) begin
      cnt_r <= '0;
    end else if (ifst_r == IF_GATE && rise[SY_IF]) begin
      cnt_r <= cnt_r + 20'h00001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fm_path_active <= 1'b0;
      if_sensitivity_select <= 1'b1;
      count_busy <= 1'b0;
      count_done <= 1'b0;
    end else begin
      fm_path_active <= cfg_r[FM_SEL_BIT];
      if_sensitivity_select <= cfg_r[IF_SENS_BIT];
      count_busy <= (ifst_r == IF_WAIT) || (ifst_r == IF_GATE);
      count_done <= (ifst_r == IF_DONE);
    end
  end

  assign div_pulse = div_pulse_r;
  assign link.do_o = do_o_r;
  assign link.do_oe = do_oe_r;
endmodule
`default_nettype wire

// File: core/plp_host.sv
// Host end: drives strobe, serial clock and data; reads the output frame.
// Assumes the device samples data on rising clock edges within the strobe.
`timescale 1ns/1ns
`default_nettype none
module plp_host
  import plp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  plp_link_if.host link,
  input wire logic wr_req,
  input wire logic [CFG_W-1:0] wr_data,
  input wire logic rd_req,
  output logic busy,
  output logic [OUT_W-1:0] rd_data,
  output logic rd_valid
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_HOLD = 3'b100,
    H_GAP = 3'b101
  } plp_hst_t;

  plp_hst_t st_r;
  logic [7:0] tm_r;
  logic [4:0] idx_r, nbits_r;
  logic [IN_BITS-1:0] tx_r;
  logic rd_r, ce_r, sck_r, sin_r;
  logic s1_r, s2_r, s3_r, dof_r;
  logic tm_end;

  // Returned line is asynchronous to us
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dof_r <= 1'b1;
    end else begin
      s1_r <= link.do_line;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dof_r <= s3_r;
      end
    end
  end

  assign tm_end = (tm_r == 8'(HALF_CYC - 1));

  // Clock idles low; are the user's duty at wr_req/rd_req
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= H_IDLE;
      tm_r <= 8'h00;
      idx_r <= 5'h00;
      nbits_r <= 5'h00;
      tx_r <= '0;
      rd_r <= 1'b0;
      ce_r <= 1'b0;
      sck_r <= 1'b0;
      sin_r <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      tm_r <= tm_end ? 8'h00 : tm_r + 8'h01;
      unique case (st_r)
        H_IDLE: begin
          tm_r <= 8'h00;
          idx_r <= 5'h00;
          if (wr_req || rd_req) begin
            tx_r <= wr_req ? {wr_data, MODE_WRITE} : {{CFG_W{1'b0}}, MODE_READ};
            nbits_r <= wr_req ? 5'(IN_BITS) : 5'(RD_BITS);
            rd_r <= !wr_req;
            ce_r <= 1'b1;
            busy <= 1'b1;
            st_r <= H_SETUP;
          end
        end
        H_SETUP: if (tm_end) begin
          sin_r <= tx_r[0];
          st_r <= H_LOW;
        end
        H_LOW: if (tm_end) begin
          if (rd_r && idx_r != 5'h00) begin
            rd_data <= {rd_data[OUT_W-2:0], dof_r};
          end
          sck_r <= 1'b1;
          st_r <= H_HIGH;
        end
        H_HIGH: if (tm_end) begin
          sck_r <= 1'b0;
          tx_r <= {1'b0, tx_r[IN_BITS-1:1]};
          idx_r <= idx_r + 5'h01;
          if (idx_r == nbits_r - 5'h01) begin
            st_r <= H_HOLD;
          end else begin
            sin_r <= tx_r[1];
            st_r <= H_LOW;
          end
        end
        H_HOLD: if (tm_end) begin
          ce_r <= 1'b0;
          sin_r <= 1'b0;
          st_r <= H_GAP;
        end
        H_GAP: if (tm_end) begin
          rd_valid <= rd_r;
          busy <= 1'b0;
          st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.ce = ce_r;
  assign link.serial_clock_pin = sck_r;
  assign link.serial_in_pin = sin_r;
endmodule
`default_nettype wire

// File: testbench/plp_checker.sv
// Checker for the control link between host end and device end.
// Assumes it watches the interface that joins the two design ends.
`timescale 1ns/1ns
`default_nettype none
module plp_checker
  import plp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic do_o,
  input wire logic do_oe,
  input wire logic do_line
);
  int hi_cnt_r;
  int lo_cnt_r;
  int ce_cnt_r;
  logic low_ph;
  localparam int MIN_CYC = LINK_MIN_NS / CLK_NS;

  assign low_ph = ce && !serial_clock_pin;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt_r <= 0;
      lo_cnt_r <= 0;
    end else begin
      hi_cnt_r <= serial_clock_pin ? hi_cnt_r + 1 : 0;
      lo_cnt_r <= serial_clock_pin ? 0 : lo_cnt_r + 1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ce_cnt_r <= 0;
    else ce_cnt_r <= ce ? ce_cnt_r + 1 : 0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  clk_idle_a: assert property (!ce |-> !serial_clock_pin)
    else $error("serial clock high outside frame");
  clk_gated_a: assert property ($changed(serial_clock_pin) |-> ce)
    else $error("serial clock moved without strobe");
  high_half_a: assert property ($fell(serial_clock_pin) |-> hi_cnt_r == HALF_CYC)
    else $error("clock high half wrong length");
  low_half_a: assert property ($rose(serial_clock_pin) |-> lo_cnt_r >= HALF_CYC)
    else $error("clock low half too short");
  ce_setup_a: assert property ($rose(serial_clock_pin) |-> ce_cnt_r >= MIN_CYC)
    else $error("strobe setup too short");
  ce_hold_a: assert property ($fell(ce) |-> lo_cnt_r >= MIN_CYC)
    else $error("strobe hold too short");
  data_hold_a: assert property (serial_clock_pin |-> $stable(serial_in_pin))
    else $error("data moved while clock high");
  drive_frame_a: assert property (!ce [*8] |-> !do_oe)
    else $error("output line driven outside frame");
  drive_low_a: assert property (do_oe |-> !do_o && !do_line && (ce || $past(ce, 8)))
    else $error("output line driven wrong or outside frame");
  out_stable_a: assert property (low_ph && lo_cnt_r > 20 |-> $stable(do_line))
    else $error("output bit moved before clock rise");

  cover property ($fell(ce));
  cover property ($rose(do_oe));
  cover property (low_ph && !do_line && lo_cnt_r == 50);
endmodule
`default_nettype wire

// File: testbench/pll_divider_and_if_counter_tb_top.sv
// Bench: host end and device end joined by the link, driven from the user side.
// Assumes a shortened millisecond so gate and wait times stay brief.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module pll_divider_and_if_counter_tb_top
  import plp_pkg::*;
();
  localparam int MSC = 50;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wr_req = 1'b0, rd_req = 1'b0, lock_ok = 1'b1, io1 = 1'b0, io2 = 1'b0;
  logic [2:0] rf = 3'h0;
  logic [CFG_W-1:0] wr_data = CFG_RST;
  logic [CFG_W-1:0] cfg;
  logic [OUT_W-1:0] rd_data, q;
  logic div_pulse, fm_act, sens_o, cbusy, cdone, busy, rd_valid;
  logic [15:0] dv[4] = '{16'h0110, 16'h0110, 16'h0045, 16'h0110};
  logic [3:0] fm_sel_v = 4'b1001;
  logic [3:0] am_fast_v = 4'b0011;
  int eff[3] = '{544, 272, 4};
  int error_cnt = 0, num_checks = 0, cyc = 0, dp_n = 0, g, k;

  plp_link_if plp_link_if_i ();
  plp_dev #(.MS_CYCLES(MSC)) plp_dev_i (.mclk(mclk), .rstn(rstn), .link(plp_link_if_i),
    .fm_rf_input(rf[0]), .am_rf_input(rf[1]), .if_pulse_input(rf[2]), .lock_ok(lock_ok),
    .io1_level(io1), .io2_level(io2), .div_pulse(div_pulse), .fm_path_active(fm_act),
    .if_sensitivity_select(sens_o), .count_busy(cbusy), .count_done(cdone));
  plp_host plp_host_i (.mclk(mclk), .rstn(rstn), .link(plp_link_if_i), .wr_req(wr_req),
    .wr_data(wr_data), .rd_req(rd_req), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));
  plp_checker plp_checker_i (.mclk(mclk), .rstn(rstn), .ce(plp_link_if_i.ce),
    .serial_clock_pin(plp_link_if_i.serial_clock_pin),
    .serial_in_pin(plp_link_if_i.serial_in_pin), .do_o(plp_link_if_i.do_o),
    .do_oe(plp_link_if_i.do_oe), .do_line(plp_link_if_i.do_line));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Longest run is near 91000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (div_pulse === 1'b1) dp_n <= dp_n + 1;
    if (cyc == 100000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One host transfer; read data is taken in the valid cycle
  task automatic xfer(input bit w, input logic [CFG_W-1:0] d, output logic [OUT_W-1:0] r);
    int i;
    r = 'x;
    wr_data = d;
    if (w) wr_req = 1'b1;
    else rd_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    rd_req = 1'b0;
    for (i = 0; i < 9000; i++) begin
      tick(1);
      if (rd_valid === 1'b1) r = rd_data;
      if (busy === 1'b0) break;
    end
  endtask

  // Edges spaced wide enough for the input synchronisers
  task automatic pulses(input int n, input logic [2:0] m);
    repeat (n) begin
      rf = m;
      tick(6);
      rf = 3'h0;
      tick(6);
    end
  endtask

  initial begin
    tick(5);
    rstn = 1'b1;
    tick(2);
    `CHK("sens_rst", 1'b1, sens_o);
    `CHK("busy_rst", 1'b0, cbusy);
    `CHK("done_rst", 1'b0, cdone);
    `CHK("line_rst", 1'b1, plp_link_if_i.do_line);
    for (g = 0; g < 4; g++) begin
      cfg = {g[0], g[1:0], 1'b0, fm_sel_v[g], am_fast_v[g], dv[g]};
      xfer(1'b1, cfg, q);
      `CHK("fm_path", fm_sel_v[g], fm_act);
      `CHK("sens", g[0], sens_o);
      `CHK("idle", 1'b0, cbusy);
      if (g < 3) begin
        dp_n = 0;
        pulses(eff[g] - 1, 3'h3);
        tick(10);
        `CHK("div_early", 0, dp_n);
        pulses(1, 3'h3);
        tick(10);
        `CHK("div_full", 1, dp_n);
      end
      io1 = g[0];
      io2 = g[1];
      lock_ok = ~g[0];
      cfg[CNT_EN_BIT] = 1'b1;
      xfer(1'b1, cfg, q);
      `CHK("start", 1'b1, cbusy);
      tick((g[1] ? WAIT_LONG_MS : WAIT_SHORT_MS) * MSC - 60);
      pulses(6 + g, 3'h4);
      for (k = 0; k < 4000 && cdone !== 1'b1; k++) tick(1);
      `CHK("done", 1'b1, cdone);
      if (g == 3) begin
        xfer(1'b1, cfg, q);
        `CHK("relatch", 1'b0, cbusy);
        `CHK("relatch_done", 1'b1, cdone);
      end
      pulses(2, 3'h4);
      xfer(1'b0, cfg, q);
      `CHK("frame", {g[1], g[0], ~g[0], 20'(6 + g)}, q);
    end
    cfg[CNT_EN_BIT] = 1'b0;
    xfer(1'b1, cfg, q);
    `CHK("clr_done", 1'b0, cdone);
    xfer(1'b0, cfg, q);
    `CHK("cleared", 20'h00000, q[CNT_W-1:0]);
    close_out();
  end
endmodule
`default_nettype wire
